// ===== src/cdp_map.svh
// Register indices, field positions, reset values and bus constants for the divider block
//
// Contract
// - Single-stage divider delays its output rising edge by programmed input cycles.
// - Offset value is start-high flag bit 4 over phase bits 3:0; <=15 delays that.
// - Offset value 16 or more delays value minus 16 plus low field plus one.
// - New offsets apply only at a sync event; software must issue one.
// - Each high and low field holds cycle count minus one.
// - Cascaded divider has two stages of 2 to 32; total is the product.
// - Cascaded stage gives low+1 low and high+1 high input cycles; with correction on, high is half of low+high+2, rounded down.
// - Both stages bypassed divides by one; second bypassed gives first ratio alone.
// - Duty correction on by default in both stages; one bit disables both.
// - Each pair may split into single-ended A and B; B is off after reset.
// - Cascaded channel fields at div3_stage1_counts, div3_stage_bypass, div3_correction_control; second channel mirrors them.
// - Without correction high time is high+1 of high+low+2 cycles.
`ifndef CDP_MAP_SVH
`define CDP_MAP_SVH

// Register indices; byte address is four times the index
`define CDP_IDX_D0_COUNTS   10'h190
`define CDP_IDX_D0_START    10'h191
`define CDP_IDX_D0_DCC      10'h192
`define CDP_IDX_D1_COUNTS   10'h193
`define CDP_IDX_D1_START    10'h194
`define CDP_IDX_D1_DCC      10'h195
`define CDP_IDX_D2_COUNTS   10'h196
`define CDP_IDX_D2_START    10'h197
`define CDP_IDX_D2_DCC      10'h198
`define CDP_IDX_D3_STAGE1   10'h199
`define CDP_IDX_D3_STAGE2   10'h19b
`define CDP_IDX_D3_BYPASS   10'h19c
`define CDP_IDX_D3_DCC      10'h19d
`define CDP_IDX_D4_STAGE1   10'h19e
`define CDP_IDX_D4_STAGE2   10'h1a0
`define CDP_IDX_D4_BYPASS   10'h1a1
`define CDP_IDX_D4_DCC      10'h1a2
`define CDP_IDX_OUT_CFG     10'h1a3
`define CDP_IDX_SYNC        10'h1a4
`define CDP_IDX_STATUS      10'h1a5

// Storage slots
`define CDP_NUM_SLOTS       18
`define CDP_SLOT_W          5
`define CDP_SLOT_CASC       5'h09
`define CDP_SLOT_OUT_CFG    5'h11

// Field positions
`define CDP_LOW_MSB         7
`define CDP_LOW_LSB         4
`define CDP_HIGH_MSB        3
`define CDP_HIGH_LSB        0
`define CDP_PO_MSB          3
`define CDP_START_HIGH_BIT  4
`define CDP_BYP_SINGLE_BIT  7
`define CDP_BYP_STAGE1_BIT  4
`define CDP_BYP_STAGE2_BIT  5
`define CDP_DCC_OFF_BIT     0
`define CDP_SYNC_BIT        0

// Reset values
`define CDP_RST_REG         8'h00
`define CDP_RST_OUT_B       2'h0

// Offset arithmetic
`define CDP_OFFSET_SPLIT    5'h10
`define CDP_RATIO_ADD       6'h02

// Bus
`define CDP_HTRANS_NONSEQ_BIT 1
`define CDP_HRESP_OKAY      1'b0

`endif

// ===== src/cdp_pkg.sv
// Types shared by the divider block
package cdp_pkg;

  typedef enum logic [2:0] {
    CDP_ST_WAIT = 3'b001,
    CDP_ST_HIGH = 3'b010,
    CDP_ST_LOW  = 3'b100
  } cdp_phase_t;

  typedef struct packed {
    cdp_phase_t phase;
    logic [4:0] cnt;
    logic [4:0] dly;
    logic       out;
  } cdp_cell_state_t;

  typedef struct packed {
    logic [17:0][7:0] regs;
    logic             wrPend;
    logic [4:0]       wrSlot;
    logic             wrSync;
    logic [7:0]       rdData;
    logic             syncP;
    logic [1:0]       outB;
  } cdp_top_state_t;

endpackage

// ===== src/cdp_div_cell.sv
// One divider stage with start delay, bypass and duty correction
`timescale 1ns/1ps
`include "cdp_map.svh"
module cdp_div_cell (
  input  wire logic       mclk,      // System clock
  input  wire logic       reset,     // Synchronous reset
  input  wire logic       tick,      // Rising edge of divider input clock
  input  wire logic       syncPulse, // Restart request
  input  wire logic       bypass,    // Divide by one
  input  wire logic       dccOn,     // Duty correction enabled
  input  wire logic [3:0] lowCnt,    // Low cycles minus one
  input  wire logic [3:0] highCnt,   // High cycles minus one
  input  wire logic [4:0] offset,    // Start delay in input cycles
  output logic            rise,      // Output rising edge this cycle
  output logic            clkOut,    // Divided clock
  output logic            running    // Past start delay
);
  import cdp_pkg::*;

  cdp_cell_state_t s_ff;
  cdp_cell_state_t nxt_s;
  logic [5:0]      ratio;
  logic [4:0]      hiLen;
  logic [4:0]      loLen;

  always_comb begin
    ratio = {2'h0, lowCnt} + {2'h0, highCnt} + `CDP_RATIO_ADD;
    // Input has rising edges only, so correction rounds high time down
    hiLen = dccOn ? ratio[5:1] : ({1'b0, highCnt} + 5'h01);
    loLen = 5'(ratio - {1'b0, hiLen});
  end

  always_comb begin
    nxt_s = s_ff;
    rise  = 1'b0;
    if (syncPulse) begin
      nxt_s.phase = CDP_ST_WAIT;
      nxt_s.dly   = offset;
      nxt_s.cnt   = 5'h00;
      nxt_s.out   = 1'b0;
    end else if (tick) begin
      if (bypass) begin
        nxt_s.phase = CDP_ST_HIGH;
        nxt_s.out   = 1'b1;
        rise        = 1'b1;
      end else begin
        case (s_ff.phase)
          CDP_ST_WAIT: begin
            if (s_ff.dly == 5'h00) begin
              nxt_s.phase = CDP_ST_HIGH;
              nxt_s.out   = 1'b1;
              nxt_s.cnt   = hiLen - 5'h01;
              rise        = 1'b1;
            end else begin
              nxt_s.dly = s_ff.dly - 5'h01;
            end
          end
          CDP_ST_HIGH: begin
            if (s_ff.cnt == 5'h00) begin
              nxt_s.phase = CDP_ST_LOW;
              nxt_s.out   = 1'b0;
              nxt_s.cnt   = loLen - 5'h01;
            end else begin
              nxt_s.cnt = s_ff.cnt - 5'h01;
            end
          end
          CDP_ST_LOW: begin
            if (s_ff.cnt == 5'h00) begin
              nxt_s.phase = CDP_ST_HIGH;
              nxt_s.out   = 1'b1;
              nxt_s.cnt   = hiLen - 5'h01;
              rise        = 1'b1;
            end else begin
              nxt_s.cnt = s_ff.cnt - 5'h01;
            end
          end
          default: begin
            nxt_s.phase = CDP_ST_WAIT;
          end
        endcase
      end
    end else if (bypass) begin
      // Bypassed output is a one-cycle copy of each input edge
      nxt_s.out = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_ff <= '{phase: CDP_ST_WAIT, cnt: 5'h00, dly: 5'h00, out: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign clkOut  = s_ff.out;
  assign running = (s_ff.phase != CDP_ST_WAIT);

endmodule

// ===== src/cdp_channel_divider.sv
// Five channel dividers, coarse start delay on 0 to 2 only, behind an AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cdp_map.svh"
module cdp_channel_divider (
  input  wire logic        mclk,        // System clock, 50 MHz
  input  wire logic        reset,       // Synchronous reset, active high
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready in
  output logic             hreadyout,   // Slave ready
  output logic             hresp,       // Response, always OKAY
  output logic [31:0]      hrdata,      // Read data
  input  wire logic        divClkTick,  // One pulse per divider input rising edge
  output logic [4:0]       divOut,      // Channel outputs, A side for 3 and 4
  output logic [1:0]       divOutB      // Single-ended B outputs of channels 3 and 4
);
  import cdp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [5:0] slot_of(input logic [31:0] a);
    logic [9:0] ix;
    logic [5:0] r;
    ix = a[11:2];
    r  = 6'h00;
    if (a[31:12] != 20'h00000 || a[1:0] != 2'h0) begin
      r = 6'h00;
    end else if (ix == `CDP_IDX_D0_COUNTS) begin
      r = 6'h20;
    end else if (ix == `CDP_IDX_D0_START) begin
      r = 6'h21;
    end else if (ix == `CDP_IDX_D0_DCC) begin
      r = 6'h22;
    end else if (ix == `CDP_IDX_D1_COUNTS) begin
      r = 6'h23;
    end else if (ix == `CDP_IDX_D1_START) begin
      r = 6'h24;
    end else if (ix == `CDP_IDX_D1_DCC) begin
      r = 6'h25;
    end else if (ix == `CDP_IDX_D2_COUNTS) begin
      r = 6'h26;
    end else if (ix == `CDP_IDX_D2_START) begin
      r = 6'h27;
    end else if (ix == `CDP_IDX_D2_DCC) begin
      r = 6'h28;
    end else if (ix == `CDP_IDX_D3_STAGE1) begin
      r = 6'h29;
    end else if (ix == `CDP_IDX_D3_STAGE2) begin
      r = 6'h2a;
    end else if (ix == `CDP_IDX_D3_BYPASS) begin
      r = 6'h2b;
    end else if (ix == `CDP_IDX_D3_DCC) begin
      r = 6'h2c;
    end else if (ix == `CDP_IDX_D4_STAGE1) begin
      r = 6'h2d;
    end else if (ix == `CDP_IDX_D4_STAGE2) begin
      r = 6'h2e;
    end else if (ix == `CDP_IDX_D4_BYPASS) begin
      r = 6'h2f;
    end else if (ix == `CDP_IDX_D4_DCC) begin
      r = 6'h30;
    end else if (ix == `CDP_IDX_OUT_CFG) begin
      r = 6'h31;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Divider state

  cdp_top_state_t s_ff;
  cdp_top_state_t nxt_s;
  logic [4:0]     running;
  logic [4:0]     cellOut;
  logic           addrPhase;
  logic [5:0]     aSlot;
  logic           aSync;
  logic           aStatus;
  logic [7:0]     rdValue;
  logic [7:0]     fwdValue;

  //////////////////////////////////////////////////////////////////////////////
  // Single-stage dividers 0 to 2

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_single
      logic [7:0] cntReg;
      logic [7:0] startReg;
      logic [4:0] phi;
      logic [4:0] dlyCycles;
      assign cntReg   = s_ff.regs[3*gi];
      assign startReg = s_ff.regs[3*gi+1];
      assign phi      = {startReg[`CDP_START_HIGH_BIT], startReg[`CDP_PO_MSB:0]};
      // Case split on start-high flag: low field plus one joins the delay
      assign dlyCycles = (phi < `CDP_OFFSET_SPLIT) ? phi
                       : 5'(phi - `CDP_OFFSET_SPLIT
                            + {1'b0, cntReg[`CDP_LOW_MSB:`CDP_LOW_LSB]} + 5'h01);

      cdp_div_cell u_cell (
        .mclk      (mclk),
        .reset     (reset),
        .tick      (divClkTick),
        .syncPulse (s_ff.syncP),
        .bypass    (startReg[`CDP_BYP_SINGLE_BIT]),
        .dccOn     (~s_ff.regs[3*gi+2][`CDP_DCC_OFF_BIT]),
        .lowCnt    (cntReg[`CDP_LOW_MSB:`CDP_LOW_LSB]),
        .highCnt   (cntReg[`CDP_HIGH_MSB:`CDP_HIGH_LSB]),
        .offset    (dlyCycles),
        .rise      (),
        .clkOut    (cellOut[gi]),
        .running   (running[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Cascaded dividers 3 and 4

  genvar gj;
  generate
    for (gj = 0; gj < 2; gj++) begin : g_casc
      logic [7:0] st1Reg;
      logic [7:0] st2Reg;
      logic [7:0] bypReg;
      logic       dccOn;
      logic       st1Rise;
      logic       st1Run;
      assign st1Reg = s_ff.regs[9+4*gj];
      assign st2Reg = s_ff.regs[10+4*gj];
      assign bypReg = s_ff.regs[11+4*gj];
      assign dccOn  = ~s_ff.regs[12+4*gj][`CDP_DCC_OFF_BIT];

      // Stage one edges clock stage two, so the ratios multiply
      cdp_div_cell u_stage1 (
        .mclk      (mclk),
        .reset     (reset),
        .tick      (divClkTick),
        .syncPulse (s_ff.syncP),
        .bypass    (bypReg[`CDP_BYP_STAGE1_BIT]),
        .dccOn     (dccOn),
        .lowCnt    (st1Reg[`CDP_LOW_MSB:`CDP_LOW_LSB]),
        .highCnt   (st1Reg[`CDP_HIGH_MSB:`CDP_HIGH_LSB]),
        .offset    (5'h00),
        .rise      (st1Rise),
        .clkOut    (),
        .running   (st1Run)
      );

      cdp_div_cell u_stage2 (
        .mclk      (mclk),
        .reset     (reset),
        .tick      (st1Rise),
        .syncPulse (s_ff.syncP),
        .bypass    (bypReg[`CDP_BYP_STAGE2_BIT]),
        .dccOn     (dccOn),
        .lowCnt    (st2Reg[`CDP_LOW_MSB:`CDP_LOW_LSB]),
        .highCnt   (st2Reg[`CDP_HIGH_MSB:`CDP_HIGH_LSB]),
        .offset    (5'h00),
        .rise      (),
        .clkOut    (cellOut[3+gj]),
        .running   (running[3+gj])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register slave

  always_comb begin
    addrPhase = hsel & hready & htrans[`CDP_HTRANS_NONSEQ_BIT];
    aSlot     = slot_of(haddr);
    aSync     = (haddr[31:12] == 20'h00000) && (haddr[11:2] == `CDP_IDX_SYNC)
                && (haddr[1:0] == 2'h0);
    aStatus   = (haddr[31:12] == 20'h00000) && (haddr[11:2] == `CDP_IDX_STATUS)
                && (haddr[1:0] == 2'h0);
    rdValue   = 8'h00;
    if (aSlot[5]) begin
      rdValue = s_ff.regs[aSlot[4:0]];
    end else if (aStatus) begin
      rdValue = {3'h0, running};
    end
    // A read right behind a write to the same register sees the new byte
    fwdValue = rdValue;
    if (s_ff.wrPend && aSlot[5] && (aSlot[4:0] == s_ff.wrSlot)) begin
      fwdValue = hwdata[7:0];
    end
  end

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.syncP  = 1'b0;
    nxt_s.wrPend = 1'b0;
    nxt_s.wrSync = 1'b0;
    if (s_ff.wrPend) begin
      nxt_s.regs[s_ff.wrSlot] = hwdata[7:0];
    end
    if (s_ff.wrSync && hwdata[`CDP_SYNC_BIT]) begin
      nxt_s.syncP = 1'b1;
    end
    if (addrPhase) begin
      if (hwrite) begin
        nxt_s.wrPend = aSlot[5];
        nxt_s.wrSlot = aSlot[4:0];
        nxt_s.wrSync = aSync;
      end else begin
        nxt_s.rdData = fwdValue;
      end
    end
    // B outputs follow their A outputs only while enabled
    nxt_s.outB = cellOut[4:3] & s_ff.regs[`CDP_SLOT_OUT_CFG][1:0];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_ff        <= '0;
      s_ff.outB   <= `CDP_RST_OUT_B;
      for (int k = 0; k < `CDP_NUM_SLOTS; k++) begin
        s_ff.regs[k] <= `CDP_RST_REG;
      end
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = `CDP_HRESP_OKAY;
  assign hrdata    = {24'h000000, s_ff.rdData};
  assign divOut    = cellOut;
  assign divOutB   = s_ff.outB;

endmodule

// ===== test/cdp_divider_asserts.sv
// Port checker for the channel divider block
`timescale 1ns/1ps
module cdp_divider_asserts (
  input wire logic        mclk,       // Clock
  input wire logic        reset,      // Sync reset
  input wire logic        hreadyout,  // Slave ready
  input wire logic        hresp,      // Response
  input wire logic [31:0] hrdata,     // Read data
  input wire logic        divClkTick, // Input tick
  input wire logic [4:0]  divOut,     // Channel outputs
  input wire logic [1:0]  divOutB     // B outputs
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  property p_rise_single;
    |(divOut[2:0] & ~$past(divOut[2:0])) |-> $past(divClkTick);
  endproperty
  a_rise_single: assert property (p_rise_single)
    else $error("single divider rose without a tick");
  property p_rise_casc;
    |(divOut[4:3] & ~$past(divOut[4:3])) |-> $past(divClkTick);
  endproperty
  a_rise_casc: assert property (p_rise_casc)
    else $error("cascaded divider rose without a tick");
  property p_outb_a;
    divOutB[0] |-> $past(divOut[3]);
  endproperty
  a_outb_a: assert property (p_outb_a)
    else $error("B output of channel 3 not following A");
  property p_outb_b;
    $rose(divOutB[1]) |-> $past(divOut[4]);
  endproperty
  a_outb_b: assert property (p_outb_b)
    else $error("B output of channel 4 not following A");
  property p_outb_rst;
    $fell(reset) |-> (divOutB == 2'h0) [*2];
  endproperty
  a_outb_rst: assert property (p_outb_rst)
    else $error("B outputs on after reset");
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready)
    else $error("slave inserted a wait state");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave response not okay");
  property p_rdata;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data upper bits set");
endmodule

bind cdp_channel_divider cdp_divider_asserts i_chk (
  .mclk(mclk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .divClkTick(divClkTick), .divOut(divOut), .divOutB(divOutB)
);

// ===== test/tb_top.sv
// Self-checking bench for the channel divider block
`timescale 1ns/1ps
`include "cdp_map.svh"
module tb_top;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        divClkTick = 1'b0;
  logic        tickEn = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [4:0]  divOut;
  logic [1:0]  divOutB;
  logic [31:0] rd;
  int          tickCnt = 0;
  int          nFail = 0;
  int          numChecks = 0;
  int          t0, t1, t2;

  cdp_channel_divider i_dut (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .divClkTick(divClkTick), .divOut(divOut), .divOutB(divOutB)
  );

  always #10 mclk = ~mclk;

  // Ticks never on two cycles running, so bypassed outputs still toggle
  always @(posedge mclk) begin
    divClkTick <= tickEn & ~divClkTick;
    if (divClkTick) begin
      tickCnt <= tickCnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      nFail++;
      summarize();
    end
  endtask

  // Entered just after a rising edge; read data is taken at the data phase edge
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, idx, 2'h0};
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    waitRdy();
    rd = hrdata;
  endtask

  task automatic waitOut(input int ch, input logic v, output int t);
    int n;
    n = 0;
    while (divOut[ch] !== v && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5000) begin
      nFail++;
      summarize();
    end
    t = tickCnt;
  endtask

  task automatic runOne(input int ch, input logic [7:0] cnt, input logic [7:0] st,
                        input logic duty_correction_disable, input logic doSync, input int eD, eH, eL);
    logic [9:0] b;
    b = 10'h190 + 10'(3 * ch);
    tickEn <= 1'b0;
    xfer(1'b1, b, cnt);
    xfer(1'b1, b + 10'h1, st);
    xfer(1'b1, b + 10'h2, {7'h0, duty_correction_disable});
    if (doSync) begin
      xfer(1'b1, `CDP_IDX_SYNC, 8'h01);
    end
    repeat (4) @(posedge mclk);
    t0 = tickCnt;
    tickEn <= 1'b1;
    waitOut(ch, 1'b1, t1);
    check(t1 - t0 - 1, eD, "start delay");
    waitOut(ch, 1'b0, t2);
    check(t2 - t1, eH, "high time");
    waitOut(ch, 1'b1, t1);
    check(t1 - t2, eL, "low time");
  endtask

  task automatic runCasc(input int ch, input logic [7:0] s1, s2, byp,
                         input logic duty_correction_disable, input int eP, eH);
    logic [9:0] b;
    b = (ch == 3) ? `CDP_IDX_D3_STAGE1 : `CDP_IDX_D4_STAGE1;
    tickEn <= 1'b1;
    xfer(1'b1, b, s1);
    xfer(1'b1, b + 10'h2, s2);
    xfer(1'b1, b + 10'h3, byp);
    xfer(1'b1, b + 10'h4, {7'h0, duty_correction_disable});
    waitOut(ch, 1'b0, t1);
    waitOut(ch, 1'b1, t1);
    waitOut(ch, 1'b0, t1);
    waitOut(ch, 1'b1, t1);
    waitOut(ch, 1'b0, t2);
    waitOut(ch, 1'b1, t2);
    check(t2 - t1, eP, "cascade period");
    waitOut(ch, 1'b0, t0);
    if (eH >= 0) begin
      check(t0 - t2, eH, "cascade high time");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    check({27'h0, divOut}, 32'h0, "outputs at reset");
    check({30'h0, divOutB}, 32'h0, "B outputs at reset");
    for (int i = 'h190; i < 'h1a4; i++) begin
      xfer(1'b0, 10'(i), 8'h0);
      check(rd, 32'h0, "reset value");
    end
    for (int i = 'h190; i < 'h1a3; i++) begin
      xfer(1'b1, 10'(i), 8'(i) ^ 8'h5a);
      xfer(1'b0, 10'(i), 8'h0);
      check(rd, (i == 'h19a || i == 'h19f) ? 32'h0 : {24'h0, 8'(i) ^ 8'h5a}, "readback");
    end
    xfer(1'b0, 10'h3ff, 8'h0);
    check(rd, 32'h0, "unmapped read");
    $display("register test done");
    runOne(0, 8'h21, 8'h0a, 1'b0, 1'b0, 0, 2, 3);
    runOne(0, 8'h21, 8'h0a, 1'b0, 1'b1, 10, 2, 3);
    runOne(1, 8'h21, 8'h0f, 1'b0, 1'b1, 15, 2, 3);
    runOne(2, 8'h21, 8'h10, 1'b0, 1'b1, 3, 2, 3);
    runOne(0, 8'h21, 8'h1f, 1'b0, 1'b1, 18, 2, 3);
    runOne(2, 8'hf0, 8'h13, 1'b1, 1'b1, 19, 1, 16);
    runOne(1, 8'h02, 8'h00, 1'b1, 1'b1, 0, 3, 1);
    runOne(0, 8'h00, 8'h80, 1'b0, 1'b1, 0, 0, 1);
    $display("single divider test done");
    // Stage settings keep equal or high-above-low fields, stage one bypassed only in the 8'h30 run
    runCasc(3, 8'h11, 8'h00, 8'h00, 1'b0, 8, 4);
    xfer(1'b1, `CDP_IDX_OUT_CFG, 8'h01);
    waitOut(3, 1'b1, t1);
    @(posedge mclk);
    check({30'h0, divOutB}, 32'h1, "B output enable");
    // Channel 4 B side stays on so its follow check sees real edges
    xfer(1'b1, `CDP_IDX_OUT_CFG, 8'h03);
    runCasc(3, 8'h11, 8'h00, 8'h20, 1'b0, 4, -1);
    runCasc(3, 8'h11, 8'h00, 8'h30, 1'b0, 1, -1);
    runCasc(4, 8'hff, 8'hff, 8'h00, 1'b0, 1024, 512);
    runCasc(4, 8'h01, 8'h01, 8'h00, 1'b1, 9, 6);
    waitOut(4, 1'b1, t1);
    @(posedge mclk);
    check({31'h0, divOutB[1]}, 32'h1, "B output 4 enable");
    $display("cascade test done");
    summarize();
  end
endmodule
